/* File: logic/evp_defines.svh */
// constants for the emergency preempt and manual override sequencer
// assumes inclusion by bare name from logic/
`ifndef EVP_DEFINES_SVH
`define EVP_DEFINES_SVH
`define F_CLR_PHASES     3'h0
`define F_CLR_TIME       3'h1
`define F_DELAY          3'h2
`define F_ACTIVE         3'h3
`define F_MAX            3'h4
`define F_MIN            3'h5
`define F_FLAGS          3'h6
`define R_MAN_MODE       5'h07
`define R_FREE_TIME      5'h0f
`define R_STATUS         5'h1f
`define CFG_RESET        16'h0000
`define FLAG_PED_TRUNC   0
`define FLAG_ALL_RED     1
`define CLK_PERIOD_NS    4
`define TICK_TIME_NS     100000000
`define TICK_CYCLES      (`TICK_TIME_NS / `CLK_PERIOD_NS)
`define FLASH_TICKS      16'h0005
`define IC_NORMAL        4'h0
`define IC_MIN_GREEN     4'h2
`define IC_HOLD          4'h6
`define IC_CLEAR         4'h9
`define MAN_OFF          16'h0000
`define MAN_ACTUATED     16'h0001
`define MAN_RECALL       16'h0002
`endif

/* File: logic/evp_pkg.sv */
// types shared by the preempt sequencer and its surroundings
// assumes eight phases on the sequencer side
package evp_pkg;
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_DELAY   = 3'b001,
		ST_ACTIVE  = 3'b010,
		ST_TRANSIT = 3'b011,
		ST_CLEAR   = 3'b100,
		ST_MINREM  = 3'b101
	} seq_state_t;
	typedef struct packed {
		logic [7:0] green;
		logic [7:0] in_service;
		logic [7:0] min_done;
		logic [7:0] permitted;
		logic [7:0] ped_enabled;
	} phase_status_t;
	typedef struct packed {
		logic [7:0] hold;
		logic [7:0] call;
		logic [7:0] force_off;
		logic [7:0] ped_restrict;
		logic [7:0] ped_call;
	} phase_cmd_t;
endpackage : evp_pkg

/* File: logic/emergency_preempt_manual_override.sv */
// emergency vehicle preempt sequencer with manual control override
// assumes phase status synchronous to CLK_SYS and a plain register port
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/10ps
`include "evp_defines.svh"

module emergency_preempt_manual_override #(
	parameter int TW          = 16,
	parameter int TICK_CYCLES = `TICK_CYCLES
) (
	input  wire logic                  CLK_SYS,
	input  wire logic                  RESETN,
	input  wire logic                  CE,
	input  wire logic [4:0]            ADDR,
	input  wire logic [15:0]           WDATA,
	input  wire logic                  WR,
	input  wire logic                  RD,
	output logic      [15:0]           RDATA,
	input  wire logic [3:0]            EMERGENCY_VEHICLE,
	input  wire logic                  MAN_ENABLE,
	input  wire logic                  MAN_ADVANCE,
	input  wire logic                  RR_OVERRIDE,
	input  wire logic [7:0]            PED_SELECT_FIRST,
	input  wire logic [7:0]            PED_SELECT_SECOND,
	input  wire evp_pkg::phase_status_t PH_STATUS,
	output evp_pkg::phase_cmd_t        PH_CMD,
	output logic                       WALK_END,
	output logic                       FDW_END,
	output logic                       ALL_RED_CLEAR,
	output logic [3:0]                 INTERVAL_CODE,
	output logic                       LIGHT9,
	output logic                       COORD_SUSPEND,
	output logic                       COORD_DISABLE
);
	if (TW < 8 || TW > 16 || TICK_CYCLES < 1) begin : g_bad_param
		$error("unsupported timer width or tick count");
	end

	// ------------------------------------------------------------
	// timebase
	// ------------------------------------------------------------
	logic [31:0] div_reg;
	logic        tick;
	assign tick = (div_reg == 32'(TICK_CYCLES - 1));
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
			div_reg <= 32'h0;
		else if (CE)
			div_reg <= tick ? 32'h0 : div_reg + 32'h1;
	end

	// ------------------------------------------------------------
	// register port
	// ------------------------------------------------------------
	logic [15:0]             cfg_reg [0:30];
	evp_pkg::seq_state_t     state_reg;
	logic [1:0]              sel_reg;
	logic                    man_reg;
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
		begin
			for (int i = 0; i < 31; i++)
				cfg_reg[i] <= `CFG_RESET;
		end
		else if (CE && WR && ADDR != `R_STATUS)
			cfg_reg[ADDR] <= WDATA;
	end
	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
			RDATA <= 16'h0;
		else if (CE && RD)
			RDATA <= (ADDR == `R_STATUS) ?
				{6'h0, man_reg, sel_reg, EMERGENCY_VEHICLE, state_reg} : cfg_reg[ADDR];
		else if (CE)
			RDATA <= 16'h0;
	end

	function automatic logic [15:0] cfg(input logic [1:0] ev, input logic [2:0] fld);
		cfg = cfg_reg[{ev, fld}];
	endfunction : cfg

	function automatic logic [7:0] phases(input logic [1:0] ev);
		phases = cfg_reg[{ev, `F_CLR_PHASES}][7:0];
	endfunction : phases

	function automatic logic [1:0] lowest(input logic [3:0] v);
		lowest = v[0] ? 2'h0 : v[1] ? 2'h1 : v[2] ? 2'h2 : 2'h3;
	endfunction : lowest

	// ------------------------------------------------------------
	// preempt sequence
	// ------------------------------------------------------------
	logic [3:0]    ev_prev_reg;
	logic [3:0]    rise;
	logic [1:0]    cand;
	logic [TW-1:0] min_reg [0:3];
	logic [TW-1:0] tmr_reg;
	logic [TW-1:0] max_reg;
	logic [TW-1:0] flash_reg;
	logic [TW-1:0] free_reg;
	logic [7:0]    clr_ph;
	logic          max_on;
	logic          busy;
	logic          latched;
	logic          start_ok;
	logic          cfg_short;
	logic          max_abort;
	logic          clr_ready;
	logic          seq_end;

	assign rise      = EMERGENCY_VEHICLE & ~ev_prev_reg;
	assign cand      = lowest(rise);
	assign clr_ph    = phases(sel_reg);
	assign busy      = (state_reg != evp_pkg::ST_IDLE);
	assign latched   = state_reg inside {evp_pkg::ST_ACTIVE, evp_pkg::ST_TRANSIT,
		evp_pkg::ST_CLEAR};
	assign cfg_short = (phases(cand) != 8'h0) &&
		(cfg(cand, `F_CLR_TIME) == 16'h0);
	assign start_ok  = (rise != 4'h0) && !RR_OVERRIDE && (min_reg[cand] == '0) &&
		(phases(cand) != 8'h0) && !cfg_short;
	assign max_on    = (cfg(sel_reg, `F_MAX) != 16'h0);
	// railroad freezes the sequence, so no abort may be seen while it holds
	assign max_abort = latched && max_on && tick && (max_reg == TW'(1)) &&
		!RR_OVERRIDE;
	assign clr_ready = ((clr_ph & ~PH_STATUS.green) == 8'h0) &&
		((~clr_ph & PH_STATUS.in_service) == 8'h0) && !EMERGENCY_VEHICLE[sel_reg];
	logic          min_open;
	assign min_open  = (clr_ph & PH_STATUS.green & ~PH_STATUS.min_done) != 8'h0;
	// must match the state machine exactly, else the free timer reloads early
	assign seq_end   = max_abort || (!RR_OVERRIDE && !min_open &&
		(state_reg == evp_pkg::ST_MINREM || (state_reg == evp_pkg::ST_CLEAR && tick &&
		!EMERGENCY_VEHICLE[sel_reg] && tmr_reg <= TW'(1))));

	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
			ev_prev_reg <= 4'h0;
		else if (CE)
			ev_prev_reg <= EMERGENCY_VEHICLE;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
		begin
			state_reg <= evp_pkg::ST_IDLE;
			sel_reg   <= 2'h0;
			tmr_reg   <= '0;
			max_reg   <= '0;
		end
		else if (CE && !RR_OVERRIDE)
		begin
			if (max_abort)
				state_reg <= evp_pkg::ST_IDLE;
			else
			begin
				case (state_reg)
				evp_pkg::ST_IDLE:
					if (start_ok)
					begin
						sel_reg   <= cand;
						tmr_reg   <= TW'(cfg(cand, `F_DELAY));
						state_reg <= evp_pkg::ST_DELAY;
					end
				evp_pkg::ST_DELAY:
					if (tmr_reg == '0)
					begin
						tmr_reg   <= TW'(cfg(sel_reg, `F_ACTIVE));
						max_reg   <= TW'(cfg(sel_reg, `F_MAX));
						state_reg <= evp_pkg::ST_ACTIVE;
					end
					else if (tick)
						tmr_reg <= tmr_reg - TW'(1);
				evp_pkg::ST_ACTIVE:
					if (tmr_reg == '0)
						state_reg <= evp_pkg::ST_TRANSIT;
					else if (tick)
						tmr_reg <= tmr_reg - TW'(1);
				evp_pkg::ST_TRANSIT:
					if (clr_ready)
					begin
						tmr_reg   <= TW'(cfg(sel_reg, `F_CLR_TIME));
						state_reg <= evp_pkg::ST_CLEAR;
					end
				evp_pkg::ST_CLEAR:
					if (tick && !EMERGENCY_VEHICLE[sel_reg])
					begin
						tmr_reg <= tmr_reg - TW'(1);
						if (tmr_reg <= TW'(1))
							state_reg <= seq_end ? evp_pkg::ST_IDLE : evp_pkg::ST_MINREM;
					end
				evp_pkg::ST_MINREM:
					if (seq_end)
						state_reg <= evp_pkg::ST_IDLE;
				default:
					state_reg <= evp_pkg::ST_IDLE;
				endcase
				if (latched && max_on && tick && max_reg != '0)
					max_reg <= max_reg - TW'(1);
			end
		end
	end

	// minimum timer held at load during its own sequence, runs afterwards
	for (genvar g = 0; g < 4; g++) begin : g_min
		always_ff @(posedge CLK_SYS)
		begin
			if (!RESETN)
				min_reg[g] <= '0;
			else if (CE)
			begin
				if (state_reg == evp_pkg::ST_IDLE && start_ok && cand == 2'(g))
					min_reg[g] <= TW'(cfg(2'(g), `F_MIN));
				else if (tick && min_reg[g] != '0 && !(busy && sel_reg == 2'(g)))
					min_reg[g] <= min_reg[g] - TW'(1);
			end
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
			flash_reg <= '0;
		else if (CE)
		begin
			if (state_reg == evp_pkg::ST_IDLE && rise != 4'h0 && cfg_short &&
				min_reg[cand] == '0)
				flash_reg <= TW'(`FLASH_TICKS);
			else if (tick && flash_reg != '0)
				flash_reg <= flash_reg - TW'(1);
		end
	end

	// ------------------------------------------------------------
	// manual control and coordinator hand-back
	// ------------------------------------------------------------
	logic       man_ok;
	logic [7:0] man_call_reg;
	logic [15:0] man_mode;
	assign man_mode = cfg_reg[`R_MAN_MODE];
	assign man_ok   = !busy && !RR_OVERRIDE && (man_mode != `MAN_OFF) &&
		(PED_SELECT_FIRST == 8'h0) && (PED_SELECT_SECOND == 8'h0) && MAN_ENABLE;

	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
			man_reg <= 1'b0;
		else if (CE)
			man_reg <= man_ok;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
			man_call_reg <= 8'h0;
		else if (CE)
			man_call_reg <= (man_call_reg & ~PH_STATUS.green) |
				((man_ok && man_mode >= `MAN_RECALL) ? PH_STATUS.permitted : 8'h0);
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
			free_reg <= '0;
		else if (CE)
		begin
			if ((latched || state_reg == evp_pkg::ST_MINREM) && seq_end ||
				man_reg && !man_ok)
				free_reg <= TW'(cfg_reg[`R_FREE_TIME]);
			else if (tick && free_reg != '0)
				free_reg <= free_reg - TW'(1);
		end
	end

	// ------------------------------------------------------------
	// registered outputs
	// ------------------------------------------------------------
	evp_pkg::phase_cmd_t cmd_next;
	logic [3:0]          code_next;
	logic                delay_exp;
	logic [15:0]         flags;
	assign delay_exp = (state_reg == evp_pkg::ST_DELAY) && (tmr_reg == '0) && !RR_OVERRIDE;
	assign flags     = cfg(sel_reg, `F_FLAGS);

	always_comb
	begin
		cmd_next  = '0;
		code_next = `IC_NORMAL;
		if (latched && !RR_OVERRIDE)
		begin
			cmd_next.ped_restrict = 8'hff;
			cmd_next.hold         = clr_ph;
			cmd_next.call         = clr_ph;
			if (state_reg != evp_pkg::ST_ACTIVE)
				cmd_next.force_off = ~clr_ph;
			if (state_reg == evp_pkg::ST_CLEAR)
				code_next = `IC_CLEAR;
			else if (state_reg == evp_pkg::ST_ACTIVE && (clr_ph & PH_STATUS.green) != 8'h0)
				code_next = `IC_HOLD;
		end
		else if (state_reg == evp_pkg::ST_MINREM)
			code_next = `IC_MIN_GREEN;
		else if (man_ok)
		begin
			cmd_next.hold = MAN_ADVANCE ? ~(PH_STATUS.green & PH_STATUS.min_done) : 8'hff;
			if (MAN_ADVANCE)
				cmd_next.force_off = PH_STATUS.green & PH_STATUS.min_done;
			if (man_mode > `MAN_RECALL)
				cmd_next.ped_call = PH_STATUS.ped_enabled;
			code_next = `IC_HOLD;
		end
		cmd_next.call = cmd_next.call | man_call_reg;
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (!RESETN)
		begin
			PH_CMD        <= '0;
			INTERVAL_CODE <= `IC_NORMAL;
			WALK_END      <= 1'b0;
			FDW_END       <= 1'b0;
			ALL_RED_CLEAR <= 1'b0;
			LIGHT9        <= 1'b0;
			COORD_SUSPEND <= 1'b0;
			COORD_DISABLE <= 1'b0;
		end
		else if (CE)
		begin
			PH_CMD        <= cmd_next;
			INTERVAL_CODE <= code_next;
			WALK_END      <= delay_exp;
			FDW_END       <= delay_exp && flags[`FLAG_PED_TRUNC];
			ALL_RED_CLEAR <= (state_reg == evp_pkg::ST_CLEAR) && flags[`FLAG_ALL_RED];
			LIGHT9        <= (state_reg == evp_pkg::ST_DELAY) || (flash_reg != '0);
			COORD_SUSPEND <= busy || man_ok || (free_reg != '0);
			COORD_DISABLE <= man_ok;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);

	chk_short_cfg_flash: assert property (CE && state_reg == evp_pkg::ST_IDLE &&
		rise == 4'h1 && phases(2'h0) != 8'h0 && cfg(2'h0, `F_CLR_TIME) == 16'h0 &&
		min_reg[0] == '0 |=> state_reg == evp_pkg::ST_IDLE && flash_reg != '0)
		else $error("short config not flashed");
	chk_min_blocks: assert property (CE && state_reg == evp_pkg::ST_IDLE &&
		min_reg[cand] != '0 |=> state_reg == evp_pkg::ST_IDLE)
		else $error("request taken while minimum ran");
	chk_no_phase: assert property (CE && state_reg == evp_pkg::ST_IDLE &&
		phases(cand) == 8'h0 |=> state_reg == evp_pkg::ST_IDLE)
		else $error("preempt without clearance phases");
	chk_delay_quiet: assert property (CE && state_reg == evp_pkg::ST_DELAY &&
		!RR_OVERRIDE |=> LIGHT9 && PH_CMD.ped_restrict == 8'h0)
		else $error("delay not quiet");
	chk_walk_end: assert property (CE && delay_exp |=> WALK_END ##1 !WALK_END || !CE)
		else $error("walk end missing");
	chk_active_noforce: assert property (CE && state_reg == evp_pkg::ST_ACTIVE &&
		!RR_OVERRIDE |=> PH_CMD.force_off == 8'h0 && PH_CMD.ped_restrict == 8'hff)
		else $error("force off during active");
	chk_transit_force: assert property (CE && state_reg == evp_pkg::ST_TRANSIT &&
		!RR_OVERRIDE |=> PH_CMD.force_off == ~clr_ph)
		else $error("non-clearance not forced");
	chk_clear_entry: assert property (CE && !RR_OVERRIDE && $past(CE) &&
		$rose(state_reg == evp_pkg::ST_CLEAR) |-> $past(clr_ready))
		else $error("clearance started early");
	chk_max_abort: assert property (CE && max_abort |=> state_reg == evp_pkg::ST_IDLE)
		else $error("maximum expiry ignored");
	chk_max_zero: assert property (CE && !RR_OVERRIDE && !max_on &&
		state_reg inside {evp_pkg::ST_ACTIVE, evp_pkg::ST_TRANSIT} |=> busy)
		else $error("zero maximum aborted");
	chk_manual_gate: assert property (CE && busy |=> !COORD_DISABLE)
		else $error("manual during preempt");
	chk_free_time: assert property (CE && free_reg != '0 |=> COORD_SUSPEND || !CE)
		else $error("coordinator released early");

	cov_full_seq: cover property (state_reg == evp_pkg::ST_CLEAR ##1
		state_reg == evp_pkg::ST_IDLE);
	cov_min_rem: cover property (state_reg == evp_pkg::ST_MINREM);
	cov_manual_adv: cover property (man_ok && MAN_ADVANCE);
	cov_tie: cover property (CE && start_ok && rise == 4'hc);
endmodule : emergency_preempt_manual_override

/* File: testbench/phase_partner.sv */
// stand-in for the phase sequencing logic: two rings of four phases, at most one green each
// assumes registered phase commands from the sequencer on the same clock
`timescale 1ns/10ps
module phase_partner #(
	parameter int MIN_CYC = 6
) (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	input  wire evp_pkg::phase_cmd_t    cmd,
	output evp_pkg::phase_status_t      status
);
	logic [7:0] green_reg;
	int         age [8];

	// ----------------------------------------------------------------
	// ring service
	// ----------------------------------------------------------------
	// a force-off ends a green only after its minimum; an empty ring serves its lowest call
	always_ff @(posedge clk)
	begin
		logic [7:0] g;
		int         c;
		g = green_reg;
		for (int i = 0; i < 8; i++)
			if (g[i] && cmd.force_off[i] && age[i] >= MIN_CYC)
				g[i] = 1'b0;
		for (int r = 0; r < 8; r += 4)
		begin
			c = -1;
			for (int i = r + 3; i >= r; i--)
				if (cmd.call[i] && !green_reg[i])
					c = i;
			if (g[r +: 4] == 4'h0 && c >= 0)
				g[c] = 1'b1;
		end
		for (int i = 0; i < 8; i++)
			age[i] <= !rst_n ? MIN_CYC : (g[i] && green_reg[i]) ? age[i] + 1 : 0;
		green_reg <= rst_n ? g : 8'h12;
	end

	always_comb
	begin
		status.green       = green_reg;
		status.in_service  = green_reg;
		status.permitted   = 8'hff;
		status.ped_enabled = 8'h0f;
		for (int i = 0; i < 8; i++)
			status.min_done[i] = green_reg[i] && age[i] >= MIN_CYC;
	end
endmodule : phase_partner

/* File: testbench/emergency_preempt_manual_override_test.sv */
// self-checking bench for the preempt sequencer and manual override
// assumes phase_partner closes the loop on the phase command and status ports
`timescale 1ns/10ps
module emergency_preempt_manual_override_test;
	localparam int TICKC = 4;
	logic                   clk_sys, resetn, ce, wr, rd, man_enable, man_advance, rr_override;
	logic                   walk_end, fdw_end, all_red, light9, coord_suspend, coord_disable;
	logic [4:0]             addr;
	logic [15:0]            wdata, rdata, rv;
	logic [3:0]             ev, icode;
	logic [7:0]             ped_a, ped_b, g_old;
	evp_pkg::phase_status_t ph_status;
	evp_pkg::phase_cmd_t    ph_cmd;
	int                     n_errors, checks_done, k;
	int                     cfg [32];

	emergency_preempt_manual_override #(.TICK_CYCLES(TICKC)) DUT (
		.CLK_SYS(clk_sys), .RESETN(resetn), .CE(ce), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .EMERGENCY_VEHICLE(ev), .MAN_ENABLE(man_enable),
		.MAN_ADVANCE(man_advance), .RR_OVERRIDE(rr_override), .PED_SELECT_FIRST(ped_a),
		.PED_SELECT_SECOND(ped_b), .PH_STATUS(ph_status), .PH_CMD(ph_cmd),
		.WALK_END(walk_end), .FDW_END(fdw_end), .ALL_RED_CLEAR(all_red),
		.INTERVAL_CODE(icode), .LIGHT9(light9), .COORD_SUSPEND(coord_suspend),
		.COORD_DISABLE(coord_disable));

	phase_partner #(.MIN_CYC(6)) partner (.clk(clk_sys), .rst_n(resetn), .cmd(ph_cmd),
		.status(ph_status));

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic check_out(input logic [39:0] got, input logic [39:0] exp, input string what);
		checks_done++;
		if (got !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : check_out

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask : cyc

	task automatic set_ev(input logic [3:0] v);
		@(posedge clk_sys);
		ev <= v;
		#1;
	endtask : set_ev

	task automatic reg_write(input logic [4:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
		if (a != 5'h1f)
			cfg[a] = d;
	endtask : reg_write

	task automatic reg_read(input logic [4:0] a);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1;
		rv = rdata;
	endtask : reg_read

	task automatic check_reg(input logic [4:0] a);
		reg_read(a);
		check_out(rv, cfg[a][15:0], "register read");
	endtask : check_reg

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : test_done

	// ----------------------------------------------------------------
	// clock, watchdog and scenarios
	// ----------------------------------------------------------------
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end

	initial
	begin
		#100000;
		n_errors++;
		$display("unexpected at %0t: watchdog expired", $time);
		test_done();
	end

	initial
	begin
		{resetn, wr, rd, man_enable, man_advance, rr_override} = '0;
		{addr, wdata, ev, ped_a, ped_b} = '0;
		ce = 1'b1;
		n_errors = 0;
		checks_done = 0;
		foreach (cfg[i]) cfg[i] = 0;
		void'($urandom(12));
		repeat (16) @(posedge clk_sys);
		resetn <= 1'b1;
		for (int a = 0; a < 32; a++)
			check_reg(a[4:0]);
		reg_write(5'h17, 16'($urandom));
		reg_write(5'h1f, 16'hffff);
		check_reg(5'h17);
		check_reg(5'h1f);
		// full sequence on input 1, no maximum, truncation and all-red flags
		reg_write(5'h00, 16'h0022);
		reg_write(5'h01, 16'h0002);
		reg_write(5'h02, 16'($urandom_range(3, 2)));
		reg_write(5'h03, 16'h0002);
		reg_write(5'h05, 16'h0008);
		reg_write(5'h06, 16'h0003);
		reg_write(5'h0f, 16'h0003);
		set_ev(4'h1);
		cyc(2);
		check_out(light9, 1, "delay indicator");
		check_out(ph_cmd, 0, "commands in delay");
		reg_read(5'h1f);
		check_out(rv & 16'h7, 1, "delay state");
		for (k = 0; k < 60 && walk_end !== 1'b1; k++) cyc(1);
		check_out(walk_end, 1, "walk end");
		check_out(fdw_end, 1, "ped clearance end");
		cyc(1);
		check_out(walk_end, 0, "walk end pulse");
		check_out(ph_cmd.ped_restrict, 8'hff, "ped restrict");
		check_out(ph_cmd.hold, 8'h22, "hold");
		check_out(ph_cmd.call, 8'h22, "call");
		check_out(icode, 6, "hold code");
		check_out(coord_suspend, 1, "coordinator suspended");
		for (k = 0; k < 40 && ph_cmd.force_off !== 8'hdd; k++) cyc(1);
		check_out(ph_cmd.force_off, 8'hdd, "force off");
		cyc(40);
		check_out(ph_status.green, 8'h22, "clearance phases green");
		reg_read(5'h1f);
		check_out(rv & 16'h7, 3, "waits for input off");
		set_ev(4'h0);
		for (k = 0; k < 20 && icode !== 4'h9; k++) cyc(1);
		check_out(icode, 9, "clearance code");
		check_out(all_red, 1, "all red clearance");
		for (k = 0; k < 40 && icode === 4'h9; k++) cyc(1);
		check_out(icode, 0, "normal after clearance");
		set_ev(4'h1);
		cyc(4);
		check_out(light9, 0, "minimum timer blocks");
		reg_read(5'h1f);
		check_out(rv & 16'h7, 0, "idle after sequence");
		check_out(coord_suspend, 1, "free time running");
		set_ev(4'h0);
		for (k = 0; k < 60 && coord_suspend !== 1'b0; k++) cyc(1);
		check_out(coord_suspend, 0, "coordinator released");
		// short configuration and unconfigured input
		reg_write(5'h08, 16'h0022);
		set_ev(4'h2);
		cyc(3);
		check_out(light9, 1, "short config flash");
		reg_read(5'h1f);
		check_out(rv & 16'h7, 0, "short config ignored");
		set_ev(4'h0);
		for (k = 0; k < 60 && light9 !== 1'b0; k++) cyc(1);
		check_out(light9, 0, "flash ends");
		set_ev(4'h4);
		cyc(3);
		check_out(light9, 0, "no clearance phases");
		set_ev(4'h0);
		// tie between inputs 3 and 4, maximum abort on input 3
		for (int b = 16; b < 32; b += 8)
			for (int f = 0; f < 4; f++)
				reg_write(5'(b + f), (f == 0) ? 16'h0022 : 16'h0001);
		reg_write(5'h14, 16'h0002);
		set_ev(4'hc);
		cyc(3);
		reg_read(5'h1f);
		check_out((rv >> 7) & 16'h3, 2, "lowest input wins");
		for (k = 0; k < 40 && rv[2:0] !== 3'h0; k++) reg_read(5'h1f);
		check_out(rv & 16'h7, 0, "maximum time abort");
		cyc(4);
		check_out(light9, 0, "held-off input stays ignored");
		set_ev(4'h0);
		rr_override <= 1'b1;
		set_ev(4'h4);
		cyc(4);
		reg_read(5'h1f);
		check_out(rv & 16'h7, 0, "railroad overrides");
		set_ev(4'h0);
		rr_override <= 1'b0;
		// manual control in every call mode
		reg_write(5'h07, 16'h0000);
		man_enable <= 1'b1;
		cyc(3);
		check_out(coord_disable, 0, "mode zero disabled");
		for (int m = 1; m < 4; m++)
		begin
			reg_write(5'h07, 16'(m));
			cyc(3);
			check_out(coord_disable, 1, "manual active");
			check_out(icode, 6, "manual hold code");
			check_out(ph_cmd.ped_call, (m == 3) ? 8'h0f : 8'h00, "ped recall");
			if (m > 1)
				check_out(ph_cmd.call | ph_status.green, 8'hff, "vehicle recall");
			g_old = ph_status.green;
			man_advance <= (m == 3);
			cyc(4);
			man_advance <= 1'b0;
			if (m == 3)
				check_out(ph_status.green & g_old, 0, "advance ends greens");
			man_enable <= 1'b0;
			cyc(2);
			check_out(coord_disable, 0, "manual off");
			check_out(coord_suspend, 1, "free time after manual");
			man_enable <= 1'b1;
		end
		ped_a <= 8'h01;
		cyc(3);
		check_out(coord_disable, 0, "ped select blocks manual");
		ped_a <= 8'h00;
		set_ev(4'h4);
		cyc(3);
		check_out(coord_disable, 0, "preempt overrides manual");
		set_ev(4'h0);
		// rv still holds an idle status from before, so always read at least once
		for (k = 0; k < 40 && (k == 0 || rv[2:0] !== 3'h0); k++) reg_read(5'h1f);
		cyc(3);
		check_out(coord_disable, 1, "manual after preempt");
		test_done();
	end
endmodule : emergency_preempt_manual_override_test
